// ---- core/modbus_port.sv ----
// RS-485 station port: address filter, rate select, write gate, silence watch, reply delay.
`timescale 1ns/1ns
`default_nettype none
`include "port_defs.svh"
module modbus_port #(
   parameter int CLK_FREQ   = `CLK_HZ,
   parameter int SEC_CYCLES = `SECOND_CYC
) (
   input  wire logic              i_clk,
   input  wire logic              i_nrst,
   input  wire logic              i_ce,
   input  wire port_pkg::wb_req_t i_wb,
   output logic [31:0]            o_wb_dat,
   output logic                   o_wb_ack,
   input  wire logic              i_rx,
   output logic                   o_tx,
   output logic                   o_tx_en,
   output logic                   o_relay_alert
);
   import port_pkg::*;

   function automatic logic [16:0] baud_div(input logic [2:0] s);
      int r;
      case (s)
         3'h0: r = `RATE_0;
         3'h1: r = `RATE_1;
         3'h2: r = `RATE_2;
         3'h3: r = `RATE_3;
         3'h4: r = `RATE_4;
         3'h5: r = `RATE_5;
         3'h6: r = `RATE_6;
         default: r = `RATE_7;
      endcase
      return 17'((CLK_FREQ + r / 2) / r);
   endfunction

   function automatic logic [7:0] delay_chars(input logic [2:0] s);
      case (s)
         3'h1: return `DLY_1;
         3'h2: return `DLY_2;
         3'h3: return `DLY_3;
         3'h4: return `DLY_4;
         3'h5: return `DLY_5;
         default: return 8'h0;
      endcase
   endfunction

   function automatic logic station_hit(input logic [7:0] st, input logic [7:0] a);
      return (st == 8'h0) ? (a == `STATION_SUBST) : (a == st);
   endfunction

   function automatic logic remote_sel(input logic [7:0] a);
      return a >= `OFS_REMOTE && a < 8'(`OFS_REMOTE + 4 * `REMOTE_REGS) && a[1:0] == 2'h0;
   endfunction

   function automatic logic [2:0] remote_idx(input logic [7:0] a);
      return 3'((a - `OFS_REMOTE) >> 2);
   endfunction

   port_cfg_t    cfg_r, cfg_nxt;
   reply_state_t st_r, st_nxt;
   logic [7:0]   remote_r [`REMOTE_REGS];
   logic [7:0]   remote_nxt [`REMOTE_REGS];
   logic [31:0]  rdat_nxt;
   logic         ack_nxt, req;
   logic [19:0]  chr_r, chr_nxt, char_len;
   logic         char_tick, frame_done, hit, ok;
   logic [2:0]   idle_r, idle_nxt;
   logic [1:0]   cnt_r, cnt_nxt;
   logic         over_r, over_nxt, infr_r, infr_nxt;
   logic [7:0]   fa_r, fa_nxt, freg_r, freg_nxt, fd_r, fd_nxt;
   logic [7:0]   wait_r, wait_nxt, stat_r, stat_nxt, nfr_r, nfr_nxt;
   logic         txs_r, txs_nxt;
   logic [7:0]   txb_r, txb_nxt;
   logic [26:0]  pre_r, pre_nxt;
   logic [6:0]   sec_r, sec_nxt;
   logic         alert_nxt, sec_tick;
   logic [7:0]   rx_byte;
   logic         rx_valid, tx_busy;

   rs485_uart u_uart (
      .i_clk      (i_clk),
      .i_nrst     (i_nrst),
      .i_ce       (i_ce),
      .i_div      (baud_div(cfg_r.baud)),
      .i_rx       (i_rx),
      .i_tx_start (txs_r),
      .i_tx_byte  (txb_r),
      .o_rx_byte  (rx_byte),
      .o_rx_valid (rx_valid),
      .o_tx       (o_tx),
      .o_tx_en    (o_tx_en),
      .o_tx_busy  (tx_busy)
   );

   always_comb begin
      cfg_nxt    = cfg_r;
      remote_nxt = remote_r;
      req        = i_wb.cyc && i_wb.stb && !o_wb_ack;
      ack_nxt    = req;
      rdat_nxt   = o_wb_dat;
      if (req && !i_wb.we) begin
         rdat_nxt = 32'h0;
         case (i_wb.adr)
            `OFS_CTRL:    rdat_nxt = {20'h0, cfg_r.permit, cfg_r.baud, cfg_r.station};
            `OFS_SILENCE: rdat_nxt = {25'h0, cfg_r.silence};
            `OFS_DELAY:   rdat_nxt = {29'h0, cfg_r.delay};
            `OFS_STATUS:  rdat_nxt = {8'h0, nfr_r, stat_r, 6'h0, st_r != TX_IDLE, o_relay_alert};
            default: begin
               if (remote_sel(i_wb.adr)) begin
                  rdat_nxt = {24'h0, remote_r[remote_idx(i_wb.adr)]};
               end
            end
         endcase
      end
      if (req && i_wb.we) begin
         case (i_wb.adr)
            `OFS_CTRL: begin
               if (i_wb.sel[0] && i_wb.dat[7:0] <= 8'(`STATION_MAX)) begin
                  cfg_nxt.station = i_wb.dat[7:0];
               end
               if (i_wb.sel[1]) begin
                  cfg_nxt.baud   = i_wb.dat[10:8];
                  cfg_nxt.permit = i_wb.dat[11];
               end
            end
            `OFS_SILENCE: begin
               if (i_wb.sel[0] && i_wb.dat[7:0] <= 8'(`SILENCE_MAX)) begin
                  cfg_nxt.silence = i_wb.dat[6:0];
               end
            end
            `OFS_DELAY: begin
               if (i_wb.sel[0] && i_wb.dat[7:0] <= 8'(`DELAY_SEL_MAX)) begin
                  cfg_nxt.delay = i_wb.dat[2:0];
               end
            end
            default: begin
               if (i_wb.sel[0] && remote_sel(i_wb.adr)) begin
                  remote_nxt[remote_idx(i_wb.adr)] = i_wb.dat[7:0];
               end
            end
         endcase
      end
      char_len   = 20'(baud_div(cfg_r.baud)) * 20'(`CHAR_BITS);
      char_tick  = chr_r >= char_len - 20'h1;
      chr_nxt    = char_tick ? 20'h0 : chr_r + 20'h1;
      frame_done = infr_r && char_tick && idle_r == 3'(`IDLE_CHARS - 1);
      hit        = station_hit(cfg_r.station, fa_r);
      ok         = !over_r && cnt_r == 2'(`FRAME_BYTES);
      idle_nxt   = idle_r;
      cnt_nxt    = cnt_r;
      over_nxt   = over_r;
      infr_nxt   = infr_r;
      fa_nxt     = fa_r;
      freg_nxt   = freg_r;
      fd_nxt     = fd_r;
      if (rx_valid) begin
         idle_nxt = 3'h0;
         infr_nxt = 1'b1;
         if (!infr_r) begin
            fa_nxt   = rx_byte;
            cnt_nxt  = 2'h1;
            over_nxt = 1'b0;
         end else if (cnt_r == 2'h1) begin
            freg_nxt = rx_byte;
            cnt_nxt  = 2'h2;
         end else if (cnt_r == 2'h2) begin
            fd_nxt  = rx_byte;
            cnt_nxt = 2'h3;
         end else begin
            over_nxt = 1'b1;
         end
      end else if (frame_done) begin
         infr_nxt = 1'b0;
      end else if (infr_r && char_tick) begin
         idle_nxt = idle_r + 3'h1;
      end
      st_nxt   = st_r;
      wait_nxt = wait_r;
      stat_nxt = stat_r;
      nfr_nxt  = nfr_r;
      txs_nxt  = 1'b0;
      txb_nxt  = txb_r;
      case (st_r)
         TX_IDLE: begin
            if (frame_done && hit && ok) begin
               st_nxt   = TX_WAIT;
               wait_nxt = delay_chars(cfg_r.delay);
               nfr_nxt  = nfr_r + 8'h1;
               if (freg_r >= 8'(`REMOTE_REGS)) begin
                  stat_nxt = `ST_BADREG;
               end else if (cfg_r.permit || freg_r == `FREE_REG_A || freg_r == `FREE_REG_B) begin
                  stat_nxt = `ST_DONE;
                  remote_nxt[freg_r[2:0]] = fd_r;
               end else begin
                  stat_nxt = `ST_REFUSED;
               end
            end
         end
         TX_WAIT: begin
            if (wait_r == 8'h0 && !tx_busy) begin
               st_nxt  = TX_ADDR;
               txs_nxt = 1'b1;
               txb_nxt = fa_r;
            end else if (char_tick && wait_r != 8'h0) begin
               wait_nxt = wait_r - 8'h1;
            end
         end
         TX_ADDR: begin
            if (!tx_busy && !txs_r) begin
               st_nxt  = TX_STAT;
               txs_nxt = 1'b1;
               txb_nxt = stat_r;
            end
         end
         TX_STAT: begin
            if (!tx_busy && !txs_r) begin
               st_nxt = TX_IDLE;
            end
         end
         default: st_nxt = TX_IDLE;
      endcase
   end

   always_comb begin
      sec_tick  = pre_r >= 27'(SEC_CYCLES - 1);
      pre_nxt   = pre_r + 27'h1;
      sec_nxt   = sec_r;
      alert_nxt = o_relay_alert;
      if (cfg_nxt.silence == 7'h0 || frame_done) begin
         pre_nxt   = 27'h0;
         sec_nxt   = 7'h0;
         alert_nxt = 1'b0;
      end else if (sec_tick) begin
         pre_nxt = 27'h0;
         if (sec_r != 7'h7f) begin
            sec_nxt = sec_r + 7'h1;
         end
         if (sec_r + 7'h1 >= cfg_nxt.silence) begin
            alert_nxt = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cfg_r         <= '{station: `RST_STATION, baud: `RST_BAUD, default: '0};
         remote_r      <= '{default: 8'h0};
         o_wb_ack      <= 1'b0;
         o_wb_dat      <= 32'h0;
         chr_r         <= 20'h0;
         idle_r        <= 3'h0;
         cnt_r         <= 2'h0;
         over_r        <= 1'b0;
         infr_r        <= 1'b0;
         fa_r          <= 8'h0;
         freg_r        <= 8'h0;
         fd_r          <= 8'h0;
         st_r          <= TX_IDLE;
         wait_r        <= 8'h0;
         stat_r        <= 8'h0;
         nfr_r         <= 8'h0;
         txs_r         <= 1'b0;
         txb_r         <= 8'h0;
         pre_r         <= 27'h0;
         sec_r         <= 7'h0;
         o_relay_alert <= 1'b0;
      end else if (i_ce) begin
         cfg_r         <= cfg_nxt;
         remote_r      <= remote_nxt;
         o_wb_ack      <= ack_nxt;
         o_wb_dat      <= rdat_nxt;
         chr_r         <= chr_nxt;
         idle_r        <= idle_nxt;
         cnt_r         <= cnt_nxt;
         over_r        <= over_nxt;
         infr_r        <= infr_nxt;
         fa_r          <= fa_nxt;
         freg_r        <= freg_nxt;
         fd_r          <= fd_nxt;
         st_r          <= st_nxt;
         wait_r        <= wait_nxt;
         stat_r        <= stat_nxt;
         nfr_r         <= nfr_nxt;
         txs_r         <= txs_nxt;
         txb_r         <= txb_nxt;
         pre_r         <= pre_nxt;
         sec_r         <= sec_nxt;
         o_relay_alert <= alert_nxt;
      end
   end

   station_range_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      cfg_r.station <= 8'(`STATION_MAX)) else $error("Station address out of range.");
   subst_reply_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (i_ce && frame_done && ok && st_r == TX_IDLE && cfg_r.station == 8'h0 && fa_r == 8'hff)
      |=> st_r == TX_WAIT) else $error("Substitute address not answered.");
   foreign_quiet_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (i_ce && frame_done && !hit && st_r == TX_IDLE) |=> st_r == TX_IDLE)
      else $error("Reply started for a foreign address.");
   char_count_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      chr_r < char_len || $changed(cfg_r.baud)) else $error("Character counter overran.");
   gate_refuse_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (i_ce && frame_done && hit && ok && st_r == TX_IDLE && !cfg_r.permit
       && freg_r < 8'h4) |=> stat_r == `ST_REFUSED) else $error("Gated write not refused.");
   free_regs_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (i_ce && frame_done && hit && ok && st_r == TX_IDLE && !cfg_r.permit
       && (freg_r == `FREE_REG_A || freg_r == `FREE_REG_B))
      |=> stat_r == `ST_DONE && remote_r[freg_r[2:0]] == fd_r) else $error("Free register refused.");
   alert_off_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      o_relay_alert |-> cfg_r.silence != 7'h0) else $error("Alert with watch disabled.");
   silence_alert_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (i_ce && sec_tick && !frame_done && cfg_nxt.silence != 7'h0
       && sec_r + 7'h1 >= cfg_nxt.silence) |=> o_relay_alert) else $error("Silence not flagged.");
   frame_restart_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (i_ce && frame_done) |=> sec_r == 7'h0 && pre_r == 27'h0 && !o_relay_alert)
      else $error("Silence timer not restarted.");
   delay_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (st_r == TX_WAIT && wait_r != 8'h0) |=> st_r == TX_WAIT) else $error("Reply delay cut short.");
   ack_pulse_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (i_ce && o_wb_ack) |=> !o_wb_ack) else $error("Ack held longer than a cycle.");
endmodule
`default_nettype wire

// ---- core/port_defs.svh ----
// Constants for the RS-485 station port: timing, limits, offsets and reset values.
`ifndef PORT_DEFS_SVH
`define PORT_DEFS_SVH
`define CLK_HZ          100000000
`define SECOND_S        1
`define SECOND_CYC      (`SECOND_S * `CLK_HZ)
`define CHAR_BITS       10
`define IDLE_CHARS      4
`define FRAME_BYTES     3
`define STATION_MAX     199
`define STATION_SUBST   8'hff
`define SILENCE_MAX     99
`define DELAY_SEL_MAX   5
`define FREE_REG_A      8'h04
`define FREE_REG_B      8'h05
`define REMOTE_REGS     8
`define RATE_0          1200
`define RATE_1          2400
`define RATE_2          4800
`define RATE_3          9600
`define RATE_4          19200
`define RATE_5          38400
`define RATE_6          57600
`define RATE_7          115200
`define DLY_1           8'd10
`define DLY_2           8'd20
`define DLY_3           8'd50
`define DLY_4           8'd100
`define DLY_5           8'd200
`define OFS_CTRL        8'h00
`define OFS_SILENCE     8'h04
`define OFS_DELAY       8'h08
`define OFS_STATUS      8'h0c
`define OFS_REMOTE      8'h10
`define RST_STATION     8'h01
`define RST_BAUD        3'h3
`define ST_DONE         8'h00
`define ST_REFUSED      8'h01
`define ST_BADREG       8'h02
`endif

// ---- core/port_pkg.sv ----
// Types shared by the RS-485 station port.
package port_pkg;
   typedef struct packed {
      logic [7:0] station;
      logic [2:0] baud;
      logic       permit;
      logic [6:0] silence;
      logic [2:0] delay;
   } port_cfg_t;
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [31:0] dat;
      logic [3:0]  sel;
   } wb_req_t;
   typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_ADDR, TX_STAT} reply_state_t;
endpackage

// ---- core/rs485_uart.sv ----
// Serial byte receiver and transmitter, 8N1, bit time given in clock cycles.
`timescale 1ns/1ns
`default_nettype none
module rs485_uart (
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   input  wire logic        i_ce,
   input  wire logic [16:0] i_div,
   input  wire logic        i_rx,
   input  wire logic        i_tx_start,
   input  wire logic [7:0]  i_tx_byte,
   output logic [7:0]       o_rx_byte,
   output logic             o_rx_valid,
   output logic             o_tx,
   output logic             o_tx_en,
   output logic             o_tx_busy
);
   logic        s1_r, s2_r;
   logic        rb_r, rb_nxt, rv_nxt;
   logic [16:0] rc_r, rc_nxt, tc_r, tc_nxt;
   logic [3:0]  rn_r, rn_nxt, tn_r, tn_nxt;
   logic [7:0]  rs_r, rs_nxt, rbyte_nxt;
   logic [9:0]  ts_r, ts_nxt;
   logic        tb_r, tb_nxt, tx_nxt;

   always_comb begin
      rb_nxt    = rb_r;
      rc_nxt    = rc_r;
      rn_nxt    = rn_r;
      rs_nxt    = rs_r;
      rv_nxt    = 1'b0;
      rbyte_nxt = o_rx_byte;
      if (!rb_r) begin
         if (!s2_r) begin
            rb_nxt = 1'b1;
            rc_nxt = {1'b0, i_div[16:1]};
            rn_nxt = 4'h0;
         end
      end else if (rc_r == 17'h0) begin
         rc_nxt = i_div - 17'h1;
         rn_nxt = rn_r + 4'h1;
         if (rn_r == 4'h0) begin
            rb_nxt = !s2_r;
         end else if (rn_r < 4'h9) begin
            rs_nxt = {s2_r, rs_r[7:1]};
         end else begin
            rb_nxt    = 1'b0;
            rv_nxt    = s2_r;
            rbyte_nxt = s2_r ? rs_r : o_rx_byte;
         end
      end else begin
         rc_nxt = rc_r - 17'h1;
      end
      tb_nxt = tb_r;
      tc_nxt = tc_r;
      tn_nxt = tn_r;
      ts_nxt = ts_r;
      tx_nxt = o_tx;
      if (!tb_r) begin
         if (i_tx_start) begin
            tb_nxt = 1'b1;
            ts_nxt = {1'b1, i_tx_byte, 1'b0};
            tc_nxt = i_div - 17'h1;
            tn_nxt = 4'h0;
            tx_nxt = 1'b0;
         end
      end else if (tc_r == 17'h0) begin
         tc_nxt = i_div - 17'h1;
         if (tn_r == 4'h9) begin
            tb_nxt = 1'b0;
            tx_nxt = 1'b1;
         end else begin
            tn_nxt = tn_r + 4'h1;
            ts_nxt = {1'b1, ts_r[9:1]};
            tx_nxt = ts_r[1];
         end
      end else begin
         tc_nxt = tc_r - 17'h1;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         s1_r       <= 1'b1;
         s2_r       <= 1'b1;
         rb_r       <= 1'b0;
         rc_r       <= 17'h0;
         rn_r       <= 4'h0;
         rs_r       <= 8'h0;
         o_rx_valid <= 1'b0;
         o_rx_byte  <= 8'h0;
         tb_r       <= 1'b0;
         tc_r       <= 17'h0;
         tn_r       <= 4'h0;
         ts_r       <= 10'h3ff;
         o_tx       <= 1'b1;
         o_tx_en    <= 1'b0;
         o_tx_busy  <= 1'b0;
      end else if (i_ce) begin
         s1_r       <= i_rx;
         s2_r       <= s1_r;
         rb_r       <= rb_nxt;
         rc_r       <= rc_nxt;
         rn_r       <= rn_nxt;
         rs_r       <= rs_nxt;
         o_rx_valid <= rv_nxt;
         o_rx_byte  <= rbyte_nxt;
         tb_r       <= tb_nxt;
         tc_r       <= tc_nxt;
         tn_r       <= tn_nxt;
         ts_r       <= ts_nxt;
         o_tx       <= tx_nxt;
         o_tx_en    <= tb_nxt;
         o_tx_busy  <= tb_nxt;
      end
   end
endmodule
`default_nettype wire

// ---- dv/modbus_master.sv ----
// Behavioural master on the RS-485 line: sends request frames, decodes replies.
`timescale 1ns/1ns
`default_nettype none
module modbus_master #(
   parameter int BIT = 868
) (
   input  wire logic i_clk,
   output logic      o_line,
   input  wire logic i_tx,
   input  wire logic i_tx_en
);
   initial o_line = 1'b1;

   // One 8N1 character, least significant bit first; line rests high after it.
   task automatic send(input logic [7:0] b);
      logic [9:0] sh;
      sh = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         o_line <= sh[i];
         repeat (BIT) @(posedge i_clk);
      end
   endtask

   // Request frame: address, register index, data, sent back to back.
   task automatic frame(input logic [7:0] a, input logic [7:0] r, input logic [7:0] d);
      send(a);
      send(r);
      send(d);
   endtask

   // Waits up to lim cycles for a start bit, then samples each bit at its middle.
   task automatic recv(input int lim, output logic [7:0] b, output logic ok);
      int k;
      k = 0;
      ok = 1'b0;
      b = 8'h00;
      while (i_tx !== 1'b0 && k < lim) begin
         @(posedge i_clk);
         k++;
      end
      if (k < lim) begin
         repeat (BIT / 2) @(posedge i_clk);
         ok = (i_tx === 1'b0) && (i_tx_en === 1'b1);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge i_clk);
            b[i] = i_tx;
         end
         repeat (BIT) @(posedge i_clk);
         ok = ok && (i_tx === 1'b1);
      end
   endtask
endmodule
`default_nettype wire

// ---- dv/rs485_modbus_port_settings_bench.sv ----
// Testbench for the RS-485 station port with a reference register model.
`timescale 1ns/1ns
`default_nettype none
module rs485_modbus_port_settings_bench;
   import port_pkg::*;
   localparam int HZ  = 2000000;
   localparam int BIT = (HZ + 57600) / 115200;
   localparam int SEC = 2000;
   logic              i_clk;
   logic              i_nrst;
   logic              i_ce;
   wb_req_t           wb;
   logic [31:0]       wb_dat;
   logic              ack;
   logic              rx;
   logic              tx;
   logic              tx_en;
   logic              alert;
   int                n_errors;
   int                n_compared;
   int                k;
   int                quiet;
   logic [31:0]       seed;
   logic [31:0]       rd;
   logic [7:0]        d;
   logic [7:0]        remote [8];

   modbus_port #(.CLK_FREQ(HZ), .SEC_CYCLES(SEC)) u_modbus_port (.i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_ce(i_ce), .i_wb(wb), .o_wb_dat(wb_dat), .o_wb_ack(ack), .i_rx(rx), .o_tx(tx),
      .o_tx_en(tx_en), .o_relay_alert(alert));
   modbus_master #(.BIT(BIT)) u_modbus_master (.i_clk(i_clk), .o_line(rx), .i_tx(tx),
      .i_tx_en(tx_en));

   always #5 i_clk = ~i_clk;

   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction

   task automatic end_sim;
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Classic single cycle; entered just after a rising edge, leaves one idle cycle.
   task automatic wb_rw(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                        output logic [31:0] rdat);
      int n;
      n = 0;
      wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, dat: dat, sel: 4'hf};
      do begin
         @(posedge i_clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) begin
         n_errors++;
         end_sim();
      end
      rdat = wb_dat;
      wb <= '0;
      @(posedge i_clk);
   endtask

   task automatic reg_chk(input string nm, input logic [7:0] adr, input logic [31:0] exp);
      logic [31:0] r;
      wb_rw(1'b0, adr, 32'h0, r);
      chk(nm, exp, r);
   endtask

   task automatic remote_chk;
      for (int i = 0; i < 8; i++) begin
         reg_chk("remote", 8'(8'h10 + 4 * i), {24'h0, remote[i]});
      end
   endtask

   // Sends one request and checks the echoed address and status, or silence.
   task automatic xact(input logic [7:0] a, input logic [7:0] r, input logic [7:0] dd,
                       input logic ans, input logic [7:0] st);
      logic [7:0] b;
      logic       ok;
      u_modbus_master.frame(a, r, dd);
      if (quiet > 0) begin
         u_modbus_master.recv(quiet * 10 * BIT, b, ok);
         chk("reply early", 32'h0, {31'h0, ok});
      end
      u_modbus_master.recv(80 * BIT, b, ok);
      chk("reply present", {31'h0, ans}, {31'h0, ok});
      if (ans && !ok) begin
         end_sim();
      end
      if (ans && ok) begin
         chk("echo addr", {24'h0, a}, {24'h0, b});
         u_modbus_master.recv(3000, b, ok);
         chk("status", {23'h0, 1'b1, st}, {23'h0, ok, b});
      end
   endtask

   initial begin
      i_clk = 1'b0;
      i_nrst = 1'b0;
      i_ce = 1'b1;
      wb = '0;
      seed = 32'h25453fac;
      n_errors = 0;
      n_compared = 0;
      quiet = 0;
      repeat (8) @(posedge i_clk);
      i_nrst <= 1'b1;
      @(posedge i_clk);
      reg_chk("ctrl", 8'h00, 32'h301);
      for (int i = 0; i < 8; i++) begin
         remote[i] = 8'h00;
         wb_rw(1'b1, 8'h00, {21'h0, i[2:0], 8'h00}, rd);
         reg_chk("ctrl", 8'h00, {21'h0, i[2:0], 8'h00});
      end
      wb_rw(1'b1, 8'h00, 32'h7c8, rd);
      reg_chk("ctrl", 8'h00, 32'h700);
      for (int i = 0; i < 8; i++) begin
         remote[i] = rnd();
         wb_rw(1'b1, 8'(8'h10 + 4 * i), {24'h0, remote[i]}, rd);
      end
      remote_chk();
      reg_chk("unmapped", 8'h40, 32'h0);
      for (int i = 0; i < 7; i++) begin
         wb_rw(1'b1, 8'h08, i, rd);
         reg_chk("delay", 8'h08, (i > 5) ? 32'h5 : i);
      end
      wb_rw(1'b1, 8'h08, 32'h0, rd);
      d = rnd();
      xact(8'hff, 8'h04, d, 1'b1, 8'h00);
      remote[4] = d;
      xact(8'hff, 8'h02, rnd(), 1'b1, 8'h01);
      xact(8'h01, 8'h05, rnd(), 1'b0, 8'h00);
      xact(8'hff, 8'h09, rnd(), 1'b1, 8'h02);
      d = rnd();
      xact(8'hff, 8'h05, d, 1'b1, 8'h00);
      remote[5] = d;
      remote_chk();
      wb_rw(1'b1, 8'h00, 32'hf05, rd);
      d = rnd();
      xact(8'h05, 8'h02, d, 1'b1, 8'h00);
      remote[2] = d;
      xact(8'hff, 8'h03, rnd(), 1'b0, 8'h00);
      wb_rw(1'b1, 8'h08, 32'h1, rd);
      quiet = 12;
      d = rnd();
      xact(8'h05, 8'h01, d, 1'b1, 8'h00);
      remote[1] = d;
      quiet = 0;
      wb_rw(1'b1, 8'h08, 32'h0, rd);
      remote_chk();
      wb_rw(1'b1, 8'h04, 32'd100, rd);
      reg_chk("silence", 8'h04, 32'h0);
      wb_rw(1'b1, 8'h04, 32'd3, rd);
      repeat (2 * SEC) @(posedge i_clk);
      chk("alert early", 32'h0, {31'h0, alert});
      i_ce <= 1'b0;
      repeat (2 * SEC) @(posedge i_clk);
      chk("alert frozen", 32'h0, {31'h0, alert});
      i_ce <= 1'b1;
      k = 0;
      while (alert !== 1'b1 && k < 5 * SEC) begin
         @(negedge i_clk);
         k++;
      end
      chk("alert", 32'h1, {31'h0, alert});
      if (alert !== 1'b1) begin
         end_sim();
      end
      d = rnd();
      xact(8'h05, 8'h00, d, 1'b1, 8'h00);
      remote[0] = d;
      chk("alert cleared", 32'h0, {31'h0, alert});
      wb_rw(1'b1, 8'h04, 32'h0, rd);
      repeat (5 * SEC) @(posedge i_clk);
      chk("alert off", 32'h0, {31'h0, alert});
      remote_chk();
      reg_chk("status", 8'h0c, 32'h00070000);
      end_sim();
   end

   initial begin
      repeat (100000) @(posedge i_clk);
      n_errors++;
      end_sim();
   end
endmodule
`default_nettype wire
